// File: hw/cmshc_regs.sv
/*
  Configuration bank with APB slave, sync control, holdover control,
  loss-of-signal detection and reference selection.
  Assumes all inputs synchronous to REF_CLK and APB zero-wait masters.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cmshc_consts.svh"
module cmshc_regs
  import cmshc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        REF_CLK,
  input  wire logic        NRST,
  input  wire logic        CE,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Datapath status
  input  wire logic        SYNC_PIN_IN,
  input  wire logic        GROUP_REG_WR,
  input  wire logic        QUAL_TICK,
  input  wire logic        LOOP1_LOCK,
  input  wire logic        LOOP2_LOCK,
  input  wire logic [1:0]  REF_ACTIVITY,
  input  wire logic [1:0]  STATUS_PIN_IN,
  // Oscillator and feedback routing
  output logic             OSC_OUTPUT_SELECT,
  output logic      [2:0]  OSC_DIVIDE_VALUE,
  output logic      [2:0]  FEEDBACK_SELECT,
  output logic             FEEDBACK_POWER,
  output logic             CRYSTAL_OSC_ENABLE,
  // Sync, lock, holdover, references
  output logic      [5:0]  GROUP_SYNC,
  output logic             SYNC_ACTIVE,
  output logic             SYNC_PIN_OUT,
  output logic             LOCK_PIN_OUT,
  output logic             HOLDOVER,
  output logic             DAC_TRACK,
  output logic      [1:0]  REF_LOSS,
  output logic             REF_SELECT,
  output logic      [1:0]  STATUS_PIN_OUT
);

  logic [31:0] osc_q;
  logic [31:0] sync_q;
  logic [31:0] lock_q;
  logic [31:0] hold_q;
  logic [31:0] loss_q;
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  cmshc_sync_e sy_q;
  cmshc_sync_e sy_d;
  cmshc_hold_e ho_q;
  cmshc_hold_e ho_d;
  logic        lock1_q;
  logic [1:0]  loss_fl_q;
  logic        sel_q;
  logic [5:0]  grp_q;
  logic        sact_q;
  logic        spin_q;
  logic        lpin_q;
  logic        trk_q;
  logic [1:0]  stpin_q;
  cmshc_cnt_t  limit;

  logic wr_en;
  logic setup;
  assign setup = PSEL & ~PENABLE;
  assign wr_en = PSEL & PENABLE & pready_q & PWRITE;

  // Cycles for a timeout, rounded up
  function automatic cmshc_cnt_t tmo_cycles(input int ns);
    int c;
    c = (ns * `CM_CLK_MHZ + 999) / 1000;
    tmo_cycles = cmshc_cnt_t'(c);
  endfunction : tmo_cycles

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == `CM_ADDR_OSC) || (a == `CM_ADDR_SYNC) ||
                (a == `CM_ADDR_LOCK) || (a == `CM_ADDR_HOLD) ||
                (a == `CM_ADDR_LOSS) || (a == `CM_ADDR_STAT);
  endfunction : is_mapped

  // Shared selector for the two status pins
  function automatic logic status_mux(input logic [2:0] s,
                                      input logic       lost,
                                      input logic       chosen);
    case (s)
      3'h1:    status_mux = 1'b1;
      3'h2:    status_mux = lost;
      3'h3:    status_mux = chosen;
      default: status_mux = 1'b0;
    endcase
  endfunction : status_mux

  // APB handshake, answered in the first access cycle
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else if (CE)
    begin
      pready_q  <= setup;
      pslverr_q <= setup & ~is_mapped(PADDR);
      if (setup)
      begin
        case (PADDR)
          `CM_ADDR_OSC:  prdata_q <= osc_q;
          `CM_ADDR_SYNC: prdata_q <= sync_q;
          `CM_ADDR_LOCK: prdata_q <= lock_q;
          `CM_ADDR_HOLD: prdata_q <= hold_q;
          `CM_ADDR_LOSS: prdata_q <= loss_q;
          `CM_ADDR_STAT: prdata_q <= {24'h00_0000, LOOP2_LOCK,
                                      LOOP1_LOCK, sel_q, loss_fl_q,
                                      sact_q, ho_q == CM_HO_HOLD,
                                      1'b0};
          default:       prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Register writes; reserved bits are never stored
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      osc_q  <= `CM_RST_OSC; // [R1]
      sync_q <= `CM_RST_SYNC; // [R1]
      lock_q <= `CM_RST_LOCK; // [R1]
      hold_q <= `CM_RST_HOLD; // [R1]
      loss_q <= `CM_RST_LOSS; // [R1]
    end
    else if (CE && wr_en)
    begin
      case (PADDR)
        `CM_ADDR_OSC:  osc_q  <= PWDATA & `CM_MSK_OSC;
        `CM_ADDR_SYNC: sync_q <= PWDATA & `CM_MSK_SYNC;
        `CM_ADDR_LOCK: lock_q <= PWDATA & `CM_MSK_LOCK;
        `CM_ADDR_HOLD: hold_q <= PWDATA & `CM_MSK_HOLD;
        `CM_ADDR_LOSS: loss_q <= PWDATA & `CM_MSK_LOSS;
        default:       ;
      endcase
    end
  end

  assign PREADY             = pready_q;
  assign PRDATA             = prdata_q;
  assign PSLVERR            = pslverr_q;
  assign OSC_OUTPUT_SELECT  = osc_q[12]; // [R2]
  assign OSC_DIVIDE_VALUE   = osc_q[10:8]; // [R2]
  assign FEEDBACK_SELECT    = osc_q[7:5]; // [R3]
  assign FEEDBACK_POWER     = osc_q[11]; // [R3]
  assign CRYSTAL_OSC_ENABLE = sync_q[5]; // [R9]

  // Inactivity timeout per reference
  always_comb
  begin
    case (loss_q[31:30]) // [R19]
      2'h0:    limit = tmo_cycles(`CM_TMO_NS0);
      2'h1:    limit = tmo_cycles(`CM_TMO_NS1);
      2'h2:    limit = tmo_cycles(`CM_TMO_NS2);
      default: limit = tmo_cycles(`CM_TMO_NS3);
    endcase
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_los
      cmshc_cnt_t cnt_q;
      always_ff @(posedge REF_CLK or negedge NRST)
      begin
        if (!NRST)
        begin
          cnt_q         <= '0;
          loss_fl_q[gi] <= 1'b0;
        end
        else if (CE)
        begin
          if (REF_ACTIVITY[gi] || !loss_q[28]) // [R20]
            cnt_q <= '0;
          else if (cnt_q < limit)
            cnt_q <= cnt_q + 10'h001;
          loss_fl_q[gi] <= loss_q[28] & ~REF_ACTIVITY[gi] &
                           (cnt_q + 10'h001 >= limit); // [R19]
        end
      end
    end
  endgenerate

  // Reference choice; auto takes reference 1 only if 0 is unusable or lost and 1 is not
  logic [1:0] ok;
  logic       pin_sel;
  assign ok      = {hold_q[6], hold_q[5]} & ~loss_fl_q; // [R18]
  assign pin_sel = STATUS_PIN_IN[0] ^ hold_q[8]; // [R17]

  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
      sel_q <= 1'b0;
    else if (CE)
    begin
      case (hold_q[11:9]) // [R16]
        `CM_SEL_REF1: sel_q <= 1'b1;
        `CM_SEL_AUTO: sel_q <= ~ok[0] & ok[1];
        `CM_SEL_PIN:  sel_q <= pin_sel;
        default:      sel_q <= 1'b0;
      endcase
    end
  end

  // Sync control
  logic pin_act;
  logic start;
  logic hold_on;
  assign pin_act = SYNC_PIN_IN ^ sync_q[16]; // [R7]
  assign start   = sync_q[26] & ((pin_act & (~sync_q[17] | QUAL_TICK)) |
                                 (sync_q[15] & GROUP_REG_WR)); // [R6] [R8]
  assign hold_on = pin_act | (lock_q[23] & ~LOOP2_LOCK) | // [R11]
                   (lock_q[22] & ~LOOP1_LOCK); // [R12]

  always_comb
  begin
    sy_d = sy_q;
    case (sy_q)
      CM_SY_IDLE:
        if (start)
          sy_d = CM_SY_ACT;
      CM_SY_ACT:
        if (!sync_q[26] || !hold_on)
          sy_d = CM_SY_IDLE;
      default: sy_d = CM_SY_IDLE;
    endcase
  end

  // Holdover: entered on loop one unlock or loss of both references
  logic unlock_edge;
  logic all_lost;
  assign unlock_edge = lock1_q & ~LOOP1_LOCK & ~hold_q[15]; // [R15]
  assign all_lost    = loss_q[28] & (ok == 2'b00);

  always_comb
  begin
    ho_d = ho_q;
    case (ho_q)
      CM_HO_NORM:
        if (lock_q[7:6] == `CM_HO_ENABLE && (unlock_edge || all_lost))
          ho_d = CM_HO_HOLD; // [R14]
      CM_HO_HOLD:
        if (lock_q[7:6] != `CM_HO_ENABLE || (LOOP1_LOCK && !all_lost))
          ho_d = CM_HO_NORM;
      default: ho_d = CM_HO_NORM;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      sy_q    <= CM_SY_IDLE;
      ho_q    <= CM_HO_NORM;
      lock1_q <= 1'b0;
    end
    else if (CE)
    begin
      sy_q    <= sy_d;
      ho_q    <= ho_d;
      lock1_q <= LOOP1_LOCK;
    end
  end

  // Registered pin and group outputs, one cycle after their causes
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      grp_q   <= 6'h00;
      sact_q  <= 1'b0;
      spin_q  <= 1'b0;
      lpin_q  <= 1'b0;
      trk_q   <= 1'b0;
      stpin_q <= 2'h0;
    end
    else if (CE)
    begin
      sact_q <= sy_d == CM_SY_ACT;
      grp_q  <= {6{sy_d == CM_SY_ACT}} & ~sync_q[25:20]; // [R4]
      case (sync_q[19:18]) // [R5]
        2'h1:    spin_q <= 1'b1;
        2'h2:    spin_q <= LOOP1_LOCK;
        2'h3:    spin_q <= LOOP2_LOCK;
        default: spin_q <= 1'b0;
      endcase
      case (lock_q[31:27]) // [R10]
        5'h01:   lpin_q <= LOOP1_LOCK;
        5'h02:   lpin_q <= LOOP2_LOCK;
        5'h03:   lpin_q <= LOOP1_LOCK & LOOP2_LOCK;
        5'h04:   lpin_q <= ho_d == CM_HO_HOLD;
        default: lpin_q <= 1'b0;
      endcase
      trk_q <= lock_q[8] & (ho_d == CM_HO_NORM); // [R13]
      stpin_q[0] <= status_mux(hold_q[14:12], loss_fl_q[0],
                               ~sel_q); // [R21]
      stpin_q[1] <= status_mux(hold_q[22:20], loss_fl_q[1],
                               sel_q); // [R21]
    end
  end

  assign GROUP_SYNC     = grp_q;
  assign SYNC_ACTIVE    = sact_q;
  assign SYNC_PIN_OUT   = spin_q;
  assign LOCK_PIN_OUT   = lpin_q;
  assign HOLDOVER       = ho_q == CM_HO_HOLD;
  assign DAC_TRACK      = trk_q;
  assign REF_LOSS       = loss_fl_q;
  assign REF_SELECT     = sel_q;
  assign STATUS_PIN_OUT = stpin_q;

endmodule : cmshc_regs
`default_nettype wire

// File: hw/cmshc_consts.svh
/*
  Constants for the clock mode, sync and holdover configuration bank.
  Assumes a 40 MHz REF_CLK and an APB master with 32-bit data.
*/
// Operation
// [R1] Reset loads every configuration field with its default value
// [R2] Bit 12 picks raw or divided oscillator; 10:8 divide value, default 2
// [R3] Bits 7:5 pick feedback output, default 0; bit 11 powers selector
// [R4] Bit 26 enables sync; bits 25:20 exclude groups; 8/9, 6/7 excluded
// [R5] Bits 19:18 choose sync pin output drive, default logic low
// [R6] Bit 17 qualifies sync operations by a clock output; only pin syncs are qualified, register-write syncs are not
// [R7] Bit 16 sets sync input polarity, default active low
// [R8] Bit 15 lets clock-group register writes start a sync
// [R9] Bit 5 enables crystal oscillator, default off
// [R10] Bits 31:27 choose lock pin output, default both loops locked
// [R11] Bit 23 holds sync state until second loop locks
// [R12] Bit 22 holds sync state until first loop locks
// [R13] Bit 8 makes tuning DAC track loop one voltage, default on
// [R14] Bits 7:6 control holdover on lock loss, default 2 enables
// [R15] Bit 15 stops loop one unlock edge from entering holdover
// [R16] Bits 11:9 choose reference selection method, default 3 manual
// [R17] Bit 8 inverts status pins used as selection inputs
// [R18] Bits 6 and 5 mark references 1 and 0 usable
// [R19] Bits 31:30 set inactivity timeout, default 1200 ns
// [R20] Bit 28 enables loss-of-signal detection, default on
// [R21] Bits 22:20 and 14:12 choose status pin outputs, default low
`ifndef CMSHC_CONSTS_SVH
`define CMSHC_CONSTS_SVH
`define CM_ADDR_OSC      8'h28
`define CM_ADDR_SYNC     8'h2C
`define CM_ADDR_LOCK     8'h30
`define CM_ADDR_HOLD     8'h34
`define CM_ADDR_LOSS     8'h38
`define CM_ADDR_STAT     8'h3C
`define CM_RST_OSC       32'h0000_0200
`define CM_RST_SYNC      32'h0581_1000
`define CM_RST_LOCK      32'h1B00_0180
`define CM_RST_HOLD      32'h3B02_0660
`define CM_RST_LOSS      32'h1200_0000
`define CM_MSK_OSC       32'h0000_1FE0
`define CM_MSK_SYNC      32'hFFFF_F020
`define CM_MSK_LOCK      32'hFFC0_01C0
`define CM_MSK_HOLD      32'hFF77_FF60
`define CM_MSK_LOSS      32'hD730_0000
`define CM_CLK_MHZ       40
`define CM_TMO_NS0       1200
`define CM_TMO_NS1       2400
`define CM_TMO_NS2       4800
`define CM_TMO_NS3       9600
`define CM_HO_ENABLE     2'h2
`define CM_SEL_REF0      3'h0
`define CM_SEL_REF1      3'h1
`define CM_SEL_AUTO      3'h2
`define CM_SEL_PIN       3'h3
`endif

// File: hw/cmshc_pkg.sv
/*
  Types for the clock mode, sync and holdover configuration bank.
  Assumes the constants header is included alongside.
*/
package cmshc_pkg;
  typedef enum logic [1:0] {
    CM_SY_IDLE = 2'b01,
    CM_SY_ACT  = 2'b10
  } cmshc_sync_e;
  typedef enum logic [1:0] {
    CM_HO_NORM = 2'b01,
    CM_HO_HOLD = 2'b10
  } cmshc_hold_e;
  typedef logic [9:0] cmshc_cnt_t;
endpackage : cmshc_pkg

// File: testbench/cmshc_props.sv
/*
  Port checker for the configuration bank, bound to cmshc_regs.
  Assumes CE high and an APB master that holds each request.
*/
`timescale 1ns/1ps
`default_nettype none
module cmshc_props
(
  // Clock and reset
  input wire logic        REF_CLK,
  input wire logic        NRST,
  // APB
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // Datapath
  input wire logic [1:0]  REF_ACTIVITY,
  input wire logic [2:0]  OSC_DIVIDE_VALUE,
  input wire logic [5:0]  GROUP_SYNC,
  input wire logic        SYNC_ACTIVE,
  input wire logic        HOLDOVER,
  input wire logic        DAC_TRACK,
  input wire logic [1:0]  REF_LOSS
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  logic [5:0] idle_q;
  logic [2:0] div_w;
  logic       wr_osc;
  logic       mapped;
  assign div_w  = PWDATA[10:8];
  assign wr_osc = PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'h28;
  assign mapped = PADDR inside {8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C};
  // Saturates so a long idle stretch never wraps back to zero
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
      idle_q <= 6'h00;
    else if (REF_ACTIVITY[0])
      idle_q <= 6'h00;
    else if (idle_q != 6'h3F)
      idle_q <= idle_q + 6'h01;
  end
  ready_after_setup_a: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready after setup");
  ready_one_cycle_a: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  unmapped_error_a: assert property (PREADY |-> PSLVERR == !mapped)
    else $error("error flag wrong for address");
  error_reads_zero_a: assert property (PREADY && PSLVERR && !PWRITE
    |-> PRDATA == 32'h0) else $error("error read not zero");
  div_follows_write_a: assert property (wr_osc |=>
    OSC_DIVIDE_VALUE == $past(div_w)) else $error("divide not stored");
  idle_no_group_a: assert property (!SYNC_ACTIVE && !$past(SYNC_ACTIVE)
    |-> GROUP_SYNC == 6'h00) else $error("group sync while idle");
  loss_clears_a: assert property (REF_ACTIVITY[0] |=> !REF_LOSS[0])
    else $error("loss not cleared by activity");
  loss_not_early_a: assert property (idle_q < 6'd40 |-> !REF_LOSS[0])
    else $error("loss raised too early");
  holdover_dac_a: assert property (HOLDOVER && $past(HOLDOVER)
    |-> !DAC_TRACK) else $error("tracking during holdover");
  cover property (wr_osc);
  cover property (PREADY && PSLVERR);
  cover property (HOLDOVER);
endmodule : cmshc_props
bind cmshc_regs cmshc_props i_props (.REF_CLK(REF_CLK), .NRST(NRST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .REF_ACTIVITY(REF_ACTIVITY), .OSC_DIVIDE_VALUE(OSC_DIVIDE_VALUE),
  .GROUP_SYNC(GROUP_SYNC), .SYNC_ACTIVE(SYNC_ACTIVE), .HOLDOVER(HOLDOVER),
  .DAC_TRACK(DAC_TRACK), .REF_LOSS(REF_LOSS));
`default_nettype wire

// File: testbench/tb_top.sv
/*
  Self-checking bench for the configuration bank over APB.
  Assumes the design files and the checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) \
  begin \
    check_count++; \
    if ((a) !== (e)) \
    begin \
      n_mismatch++; \
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, e); \
    end \
  end
module tb_top;
  logic REF_CLK, NRST, CE, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic SYNC_PIN_IN, GROUP_REG_WR, QUAL_TICK, LOOP1_LOCK, LOOP2_LOCK;
  logic OSC_OUTPUT_SELECT, FEEDBACK_POWER, CRYSTAL_OSC_ENABLE, SYNC_ACTIVE;
  logic SYNC_PIN_OUT, LOCK_PIN_OUT, HOLDOVER, DAC_TRACK, REF_SELECT;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [2:0]  OSC_DIVIDE_VALUE, FEEDBACK_SELECT;
  logic [5:0]  GROUP_SYNC;
  logic [1:0]  REF_ACTIVITY, STATUS_PIN_IN, REF_LOSS, STATUS_PIN_OUT;
  logic        er, seen;
  int          check_count = 0, n_mismatch = 0, cyc = 0;
  logic [31:0] rst_tab [5] = '{32'h0000_0200, 32'h0581_1000,
    32'h1B00_0180, 32'h3B02_0660, 32'h1200_0000};
  cmshc_regs i_dut (.REF_CLK(REF_CLK), .NRST(NRST), .CE(CE), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SYNC_PIN_IN(SYNC_PIN_IN), .GROUP_REG_WR(GROUP_REG_WR),
    .QUAL_TICK(QUAL_TICK), .LOOP1_LOCK(LOOP1_LOCK), .LOOP2_LOCK(LOOP2_LOCK),
    .REF_ACTIVITY(REF_ACTIVITY), .STATUS_PIN_IN(STATUS_PIN_IN),
    .OSC_OUTPUT_SELECT(OSC_OUTPUT_SELECT),
    .OSC_DIVIDE_VALUE(OSC_DIVIDE_VALUE), .FEEDBACK_SELECT(FEEDBACK_SELECT),
    .FEEDBACK_POWER(FEEDBACK_POWER), .CRYSTAL_OSC_ENABLE(CRYSTAL_OSC_ENABLE),
    .GROUP_SYNC(GROUP_SYNC), .SYNC_ACTIVE(SYNC_ACTIVE),
    .SYNC_PIN_OUT(SYNC_PIN_OUT), .LOCK_PIN_OUT(LOCK_PIN_OUT),
    .HOLDOVER(HOLDOVER), .DAC_TRACK(DAC_TRACK), .REF_LOSS(REF_LOSS),
    .REF_SELECT(REF_SELECT), .STATUS_PIN_OUT(STATUS_PIN_OUT));
  initial
  begin
    REF_CLK = 1'b0;
    forever #12.5 REF_CLK = ~REF_CLK;
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  // Called right after a rising edge; waits for ready without a fixed count
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    @(posedge REF_CLK);
    while (PREADY !== 1'b1)
      @(posedge REF_CLK);
    rd = PRDATA;
    er = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    // One idle edge so a following call never reassigns PSEL in this step
    @(posedge REF_CLK);
  endtask : apb
  always @(posedge REF_CLK)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial
  begin
    {NRST, PSEL, PENABLE, PWRITE, GROUP_REG_WR, QUAL_TICK} = '0;
    {PADDR, PWDATA, STATUS_PIN_IN} = '0;
    {CE, SYNC_PIN_IN, LOOP1_LOCK, LOOP2_LOCK} = 4'hF;
    REF_ACTIVITY = 2'b11;
    repeat (16) @(posedge REF_CLK);
    NRST <= 1'b1;
    @(posedge REF_CLK);
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, 8'h28 + 8'(4 * i), 32'h0);
      `CHK(rd, rst_tab[i])
    end
    `CHK(OSC_DIVIDE_VALUE, 3'h2)
    `CHK(DAC_TRACK, 1'b1)
    `CHK(LOCK_PIN_OUT, 1'b1)
    `CHK({SYNC_PIN_OUT, STATUS_PIN_OUT, REF_SELECT}, 4'h0)
    apb(1'b0, 8'h40, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    apb(1'b1, 8'h28, 32'h0000_1FE0);
    apb(1'b0, 8'h28, 32'h0);
    `CHK(rd, 32'h0000_1FE0)
    `CHK({OSC_OUTPUT_SELECT, FEEDBACK_POWER, OSC_DIVIDE_VALUE,
      FEEDBACK_SELECT}, 8'hFF)
    apb(1'b1, 8'h2C, 32'h0581_1020);
    GROUP_REG_WR <= 1'b1;
    @(posedge REF_CLK);
    GROUP_REG_WR <= 1'b0;
    repeat (3) @(posedge REF_CLK);
    `CHK({CRYSTAL_OSC_ENABLE, SYNC_ACTIVE}, 2'b10)
    SYNC_PIN_IN <= 1'b0;
    repeat (3) @(posedge REF_CLK);
    `CHK({SYNC_ACTIVE, GROUP_SYNC}, 7'h67)
    SYNC_PIN_IN <= 1'b1;
    LOOP2_LOCK  <= 1'b0;
    apb(1'b1, 8'h2C, 32'h0581_9020);
    GROUP_REG_WR <= 1'b1;
    @(posedge REF_CLK);
    GROUP_REG_WR <= 1'b0;
    seen = 1'b0;
    repeat (4)
    begin
      @(posedge REF_CLK);
      seen = seen | SYNC_ACTIVE;
    end
    `CHK({seen, LOCK_PIN_OUT}, 2'b10)
    LOOP2_LOCK   <= 1'b1;
    REF_ACTIVITY <= 2'b00;
    repeat (40) @(posedge REF_CLK);
    `CHK(REF_LOSS, 2'b00)
    repeat (20) @(posedge REF_CLK);
    `CHK({REF_LOSS, HOLDOVER, DAC_TRACK}, 4'hE)
    REF_ACTIVITY <= 2'b11;
    repeat (4) @(posedge REF_CLK);
    `CHK({REF_LOSS, HOLDOVER}, 3'h0)
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
